// ===== dv/asr_host_model.sv
`timescale 1ns/1ps
// ==========
// Host side
module asr_host_model
    import asr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        serial_result_out,
    output logic             convert_start_in,
    output logic             shift_clk_in,
    output logic             mode_select_chain_in,
    output logic             word_valid,
    output logic [15:0]      word_data
);
    initial
    begin
        convert_start_in = 1'b0;
        shift_clk_in = 1'b0;
        mode_select_chain_in = 1'b1;
        word_valid = 1'b0;
        word_data = 16'h0000;
    end
    task automatic drive(input logic cv, input logic sd);
        @(negedge clock);
        convert_start_in = cv;
        mode_select_chain_in = sd;
    endtask
    // Level set well before the edge so the synchroniser sees it
    task automatic start(input logic chain);
        drive(1'b0, ~chain);
        repeat (4) @(negedge clock);
        convert_start_in = 1'b1;
    endtask
    // Shift clock idles low between frames; 4 clocks per half period
    task automatic read(input int n, input logic [15:0] pat, input logic chain);
        logic [15:0] w;
        w = 16'h0000;
        for (int k = 0; k < n; k++)
        begin
            if (chain && k < 16)
                mode_select_chain_in = pat[15-k];
            shift_clk_in = 1'b1;
            repeat (4) @(negedge clock);
            w = {w[14:0], serial_result_out};
            shift_clk_in = 1'b0;
            if (k % 16 == 15)
            begin
                word_data = w;
                word_valid = 1'b1;
            end
            @(negedge clock);
            word_valid = 1'b0;
            repeat (3) @(negedge clock);
        end
    endtask
endmodule

// ===== dv/asr_readout_tb_top.sv
`timescale 1ns/1ps
// ==========
// Bench
module asr_readout_tb_top;
    import asr_pkg::*;
    logic        clock;
    logic        rst_n;
    logic [16:0] analog_sample_in;
    logic        convert_start_in;
    logic        shift_clk_in;
    logic        mode_select_chain_in;
    logic        serial_result_out;
    logic        serial_result_oe_n;
    logic        conv_busy;
    logic        word_valid;
    logic [15:0] word_data;
    logic [15:0] exp_q[$];
    logic [15:0] r;
    logic [15:0] p;
    int          fail_count;
    int          comparisons;
    int          seed;
    always #10 clock = ~clock;
    asr_readout u_asr_readout (.clock(clock), .rst_n(rst_n),
        .convert_start_in(convert_start_in), .shift_clk_in(shift_clk_in),
        .mode_select_chain_in(mode_select_chain_in),
        .analog_sample_in(analog_sample_in), .serial_result_out(serial_result_out),
        .serial_result_oe_n(serial_result_oe_n), .conv_busy(conv_busy));
    asr_host_model u_asr_host_model (.clock(clock), .serial_result_out(serial_result_out),
        .convert_start_in(convert_start_in), .shift_clk_in(shift_clk_in),
        .mode_select_chain_in(mode_select_chain_in), .word_valid(word_valid),
        .word_data(word_data));
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask
    // Words arrive in the order their conversions were started
    always @(posedge clock)
        if (word_valid === 1'b1)
            cmp_word("word", exp_q.pop_front(), word_data);
    // Mode 0 selects by convert low, 1 by serial input low, 2 is chain
    task automatic conv(input int m, input logic [16:0] a, input logic [15:0] e,
                        input logic [15:0] pat);
        u_asr_host_model.start(m == 2);
        analog_sample_in = a;
        exp_q.push_back(e);
        if (m == 2)
            exp_q.push_back(pat);
        repeat (10) @(negedge clock);
        cmp_bit("busy", 1'b1, conv_busy);
        if (m == 0)
            u_asr_host_model.drive(1'b0, 1'b1);
        repeat (20) @(negedge clock);
        cmp_bit("oe_n", 1'b1, serial_result_oe_n);
        repeat (70) @(negedge clock);
        cmp_bit("busy", 1'b0, conv_busy);
        if (m == 1)
            u_asr_host_model.drive(1'b1, 1'b0);
        repeat (6) @(negedge clock);
        cmp_bit("oe_n", 1'b0, serial_result_oe_n);
        u_asr_host_model.read((m == 2) ? 32 : 16, pat, m == 2);
        u_asr_host_model.drive(1'b1, 1'b1);
        repeat (6) @(negedge clock);
        if (m != 2)
            cmp_bit("oe_n", 1'b1, serial_result_oe_n);
    endtask
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        analog_sample_in = 17'h0_0000;
        seed = 67;
        fail_count = 0;
        comparisons = 0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        cmp_bit("oe_n", 1'b1, serial_result_oe_n);
        for (int i = 0; i < 6; i++)
        begin
            r = 16'($random(seed));
            p = 16'($random(seed));
            if (i == 3)
                conv(0, {2'b10, r[14:0]}, ASR_CODE_MAX, p);
            else if (i == 4)
                conv(1, {2'b11, r[14:0]}, ASR_CODE_MIN, p);
            else
                conv(i % 3, {1'b0, r}, r, p);
        end
        repeat (10) @(negedge clock);
        cmp_bit("queue_empty", 1'b1, exp_q.size() == 0);
        summarize();
    end
endmodule

// ===== include/asr_pkg.sv
package asr_pkg;

    // =========================================================
    // Result format
    localparam int          ASR_RES_BITS      = 16;
    localparam logic [15:0] ASR_CODE_MAX      = 16'hFFFF;
    localparam logic [15:0] ASR_CODE_MIN      = 16'h0000;
    localparam logic [15:0] ASR_RESULT_RST    = 16'h0000;
    localparam int          ASR_MSB_POS       = 15;
    localparam int          ASR_CHAIN_DELAY   = 16;

    // =========================================================
    // Timing
    localparam int          ASR_CLK_MHZ       = 50;
    localparam int          ASR_TCONV_NS      = 1600;
    // Conversion time is a longest time, so it rounds down
    localparam int          ASR_TCONV_CYC     = (ASR_TCONV_NS * ASR_CLK_MHZ) / 1000;
    localparam logic [6:0]  ASR_TCONV_CNT     = 7'(ASR_TCONV_CYC);

    // =========================================================
    // Modes
    typedef enum logic {ASR_MODE_CHAIN, ASR_MODE_SELECT} asr_mode_t;
    typedef enum logic [1:0] {ASR_IDLE, ASR_CONVERT, ASR_READY} asr_state_t;

endpackage

// ===== src/asr_readout.sv
`timescale 1ns/1ps

module asr_readout
    import asr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        convert_start_in,
    input  wire logic        shift_clk_in,
    input  wire logic        mode_select_chain_in,
    input  wire logic [16:0] analog_sample_in,
    output logic             serial_result_out,
    output logic             serial_result_oe_n,
    output logic             conv_busy
);

    // =========================================================
    // Pin synchronisers
    logic [1:0] cnv_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic       cnv_prev_reg;
    logic       sck_prev_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnv_sync_reg <= 2'h0;
            sck_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h3;
            cnv_prev_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            cnv_sync_reg <= {cnv_sync_reg[0], convert_start_in};
            sck_sync_reg <= {sck_sync_reg[0], shift_clk_in};
            sdi_sync_reg <= {sdi_sync_reg[0], mode_select_chain_in};
            cnv_prev_reg <= cnv_sync_reg[1];
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    logic cnv_s;
    logic sdi_s;
    logic cnv_rise;
    logic sck_rise;
    logic sck_fall;
    assign cnv_s    = cnv_sync_reg[1];
    assign sdi_s    = sdi_sync_reg[1];
    assign cnv_rise = cnv_s && !cnv_prev_reg;
    assign sck_rise = sck_sync_reg[1] && !sck_prev_reg;
    assign sck_fall = !sck_sync_reg[1] && sck_prev_reg;

    // =========================================================
    // Result coding: bit 16 of the sample flags over or under range
    function automatic logic [15:0] asr_clamp(input logic [16:0] s);
        logic [15:0] r;
        r = s[15:0];
        if (s[16])
        begin
            r = s[15] ? ASR_CODE_MIN : ASR_CODE_MAX;
        end
        return r;
    endfunction

    // =========================================================
    // Conversion sequencing
    asr_state_t state_reg;
    asr_mode_t  mode_reg;
    logic [6:0] conv_cnt_reg;
    logic [15:0] result_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mode_reg <= ASR_MODE_SELECT;
        end
        else if (cnv_rise)
        begin
            mode_reg <= sdi_s ? ASR_MODE_SELECT : ASR_MODE_CHAIN;
        end
    end

    // Counts the internal clock only, so the shift clock may idle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_reg    <= ASR_IDLE;
            conv_cnt_reg <= 7'h00;
            result_reg   <= ASR_RESULT_RST;
            conv_busy    <= 1'b0;
        end
        else if (cnv_rise)
        begin
            state_reg    <= ASR_CONVERT;
            conv_cnt_reg <= ASR_TCONV_CNT - 7'h01;
            conv_busy    <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                ASR_IDLE:
                begin
                    conv_busy <= 1'b0;
                end
                ASR_CONVERT:
                begin
                    if (conv_cnt_reg == 7'h00)
                    begin
                        result_reg <= asr_clamp(analog_sample_in);
                        state_reg  <= ASR_READY;
                        conv_busy  <= 1'b0;
                    end
                    else
                    begin
                        conv_cnt_reg <= conv_cnt_reg - 7'h01;
                    end
                end
                ASR_READY:
                begin
                    conv_busy <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // Output enable
    logic sel_en;
    logic out_en;
    // In chain mode the host reads with convert high
    assign sel_en = (mode_reg == ASR_MODE_SELECT) ? (!cnv_s || !sdi_s) : cnv_s;
    assign out_en = sel_en && (state_reg == ASR_READY);

    // =========================================================
    // Shift path: result first, then upstream chain bits
    logic [15:0] shift_reg;
    logic        was_en_reg;
    logic        sck_hi_seen_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            shift_reg          <= ASR_RESULT_RST;
            was_en_reg         <= 1'b0;
            serial_result_out  <= 1'b0;
            serial_result_oe_n <= 1'b1;
            sck_hi_seen_reg    <= 1'b0;
        end
        else
        begin
            was_en_reg         <= out_en;
            serial_result_oe_n <= !out_en;
            if (out_en && !was_en_reg)
            begin
                shift_reg         <= result_reg;
                serial_result_out <= result_reg[ASR_MSB_POS];
                sck_hi_seen_reg   <= 1'b0;
            end
            else if (out_en)
            begin
                if (sck_rise)
                begin
                    sck_hi_seen_reg <= 1'b1;
                end
                // Chain input enters at the bottom, emerges 16 clocks on
                if (sck_fall && sck_hi_seen_reg)
                begin
                    shift_reg <= {shift_reg[14:0],
                        (mode_reg == ASR_MODE_CHAIN) ? sdi_s : 1'b0};
                    serial_result_out <= shift_reg[ASR_MSB_POS - 1];
                end
            end
        end
    end

    // =========================================================
    // Checks
    sequence s_cnv_edge;
        $rose(cnv_s);
    endsequence

    a_conv_start: assert property (@(posedge clock) disable iff (!rst_n)
        s_cnv_edge |=> (state_reg == ASR_CONVERT) && conv_busy)
        else $error("Conversion did not start on convert edge");

    a_mode_chain: assert property (@(posedge clock) disable iff (!rst_n)
        (s_cnv_edge and !sdi_s) |=> mode_reg == ASR_MODE_CHAIN)
        else $error("Chain mode not latched");

    a_mode_select: assert property (@(posedge clock) disable iff (!rst_n)
        (s_cnv_edge and sdi_s) |=> mode_reg == ASR_MODE_SELECT)
        else $error("Select mode not latched");

    a_sel_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_reg == ASR_MODE_SELECT) && cnv_s && sdi_s |=> serial_result_oe_n)
        else $error("Output driven while deselected");

    a_msb_first: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(out_en) |=> !serial_result_oe_n && serial_result_out == result_reg[15])
        else $error("First bit is not the result MSB");

    a_conv_time: assert property (@(posedge clock) disable iff (!rst_n)
        s_cnv_edge ##1 (!cnv_rise) [*8] |-> state_reg == ASR_CONVERT)
        else $error("Conversion ended too early");

    // Cycles since the last convert edge; saturates so the check fires once
    logic [6:0] chk_conv_age_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            chk_conv_age_reg <= 7'h7F;
        end
        else if (cnv_rise)
        begin
            chk_conv_age_reg <= 7'h00;
        end
        else if (chk_conv_age_reg != 7'h7F)
        begin
            chk_conv_age_reg <= chk_conv_age_reg + 7'h01;
        end
    end

    a_conv_done: assert property (@(posedge clock) disable iff (!rst_n)
        chk_conv_age_reg == ASR_TCONV_CNT |-> state_reg == ASR_READY)
        else $error("Conversion did not finish in time");

    a_hiz_idle: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg != ASR_READY |=> serial_result_oe_n)
        else $error("Output driven with no result");

    a_shift_fall: assert property (@(posedge clock) disable iff (!rst_n)
        out_en && $past(out_en) && !sck_fall |=> $stable(serial_result_out))
        else $error("Output changed without falling shift clock");

endmodule
